//--- design/rpmc_pkg.sv
// Package of the periodic match counter: register map, layouts, reset values, divisors
package rpmc_pkg;

  // ************************************************************
  // Register map and bus constants
  // ************************************************************
  localparam int          AXI_ADDR_W     = 12;
  localparam logic [11:0] OFF_STATUS_CTL = 12'h000;   // status_control
  localparam logic [11:0] OFF_CUR_COUNT  = 12'h004;   // current_count
  localparam logic [11:0] OFF_MATCH_LIM  = 12'h008;   // match_limit
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int         BIT_FLAG       = 7;
  localparam int         BIT_SRC_HI     = 6;
  localparam int         BIT_SRC_LO     = 5;
  localparam int         BIT_IRQ_EN     = 4;
  localparam int         BIT_PS_HI      = 3;
  localparam int         BIT_PS_LO      = 0;
  localparam logic [7:0] RST_COUNT      = 8'h00;
  localparam logic [7:0] RST_LIMIT      = 8'h00;
  localparam logic [3:0] PS_OFF         = 4'h0;
  localparam logic [1:0] SRC_LOW_POWER  = 2'h0;
  localparam int         PRESC_W        = 18;
  localparam int         NUM_SRC        = 3;

  // Register selected by a bus address
  typedef enum logic [1:0] {
    RPMC_SEL_SC   = 2'h0,
    RPMC_SEL_CNT  = 2'h1,
    RPMC_SEL_LIM  = 2'h3,
    RPMC_SEL_NONE = 2'h2
  } rpmc_sel_type;

  // AXI4-Lite request from the master
  typedef struct packed {
    logic                  awvalid;
    logic [AXI_ADDR_W-1:0] awaddr;
    logic                  wvalid;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  bready;
    logic                  arvalid;
    logic [AXI_ADDR_W-1:0] araddr;
    logic                  rready;
  } rpmc_axi_req_type;

  // AXI4-Lite answer of the slave
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rpmc_axi_rsp_type;

  // Divide ratio for a prescale setting; 0 means off
  function automatic logic [PRESC_W-1:0] rpmc_divisor(input logic [3:0] ps, input logic hi);
    logic [PRESC_W-1:0] d;
    d = 18'h00000;
    case ({hi, ps})
      5'h01: d = 18'h00008;  5'h02: d = 18'h00020;  5'h03: d = 18'h00040;
      5'h04: d = 18'h00080;  5'h05: d = 18'h00100;  5'h06: d = 18'h00200;
      5'h07: d = 18'h00400;  5'h08: d = 18'h00001;  5'h09: d = 18'h00002;
      5'h0a: d = 18'h00004;  5'h0b: d = 18'h0000a;  5'h0c: d = 18'h00010;
      5'h0d: d = 18'h00064;  5'h0e: d = 18'h001f4;  5'h0f: d = 18'h003e8;
      5'h11: d = 18'h00400;  5'h12: d = 18'h00800;  5'h13: d = 18'h01000;
      5'h14: d = 18'h02000;  5'h15: d = 18'h04000;  5'h16: d = 18'h08000;
      5'h17: d = 18'h10000;  5'h18: d = 18'h003e8;  5'h19: d = 18'h007d0;
      5'h1a: d = 18'h01388;  5'h1b: d = 18'h02710;  5'h1c: d = 18'h04e20;
      5'h1d: d = 18'h0c350;  5'h1e: d = 18'h186a0;  5'h1f: d = 18'h30d40;
      default: d = 18'h00000;
    endcase
    return d;
  endfunction

endpackage

//--- design/rpmc_src_sync.sv
// Synchroniser and rising-edge detector for the counter's source clocks
`timescale 1ns/10ps
`default_nettype none

module rpmc_src_sync #(
  parameter int N = 3
) (
  // Clock and reset
  input  wire  logic         clk_sys,
  input  wire  logic         rst,
  // Foreign source clocks
  input  wire  logic [N-1:0] src_clk,
  // One-cycle pulse per source rising edge
  output var   logic [N-1:0] src_rise
);

  // ************************************************************
  // Per-source two-flop synchroniser, then edge stage
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : gen_src
      logic meta;
      logic sync;
      logic last;
      // Only sync reads meta; edge logic looks at sync and last
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          meta        <= 1'b0;
          sync        <= 1'b0;
          last        <= 1'b0;
          src_rise[g] <= 1'b0;
        end else begin
          meta        <= src_clk[g];
          sync        <= meta;
          last        <= sync;
          src_rise[g] <= sync & ~last;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

//--- design/rpmc_top.sv
// Periodic match counter: prescaler, 8-bit match counter and AXI4-Lite registers
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none

module rpmc_top (
  // Clock and reset
  input  wire  logic                      clk_sys,
  input  wire  logic                      rst,
  // Register bus
  input  wire  rpmc_pkg::rpmc_axi_req_type axi_req,
  output var   rpmc_pkg::rpmc_axi_rsp_type axi_rsp,
  // Source clocks from the clock generator
  input  wire  logic                      low_power_osc_clock,
  input  wire  logic                      external_ref_clock,
  input  wire  logic                      internal_ref_clock,
  // Chip mode indications
  input  wire  logic                      stop_deep,
  input  wire  logic                      debug_active,
  // Interrupt request to the processor
  output var   logic                      match_irq
);

  // ************************************************************
  // State of the block
  // ************************************************************
  typedef struct packed {
    logic                               match_flag;
    logic [1:0]                         source_clock_select;
    logic                               match_irq_enable;
    logic [3:0]                         prescale_select;
    logic [7:0]                         current_count;
    logic [7:0]                         match_limit;
    logic [rpmc_pkg::PRESC_W-1:0]       presc;
    logic                               irq;
    logic                               have_aw;
    logic [rpmc_pkg::AXI_ADDR_W-1:0]    waddr;
    logic                               have_w;
    logic [31:0]                        wdata;
    logic [3:0]                         wstrb;
    rpmc_pkg::rpmc_axi_rsp_type         rsp;
  } rpmc_state_type;

  rpmc_state_type               s;
  rpmc_state_type               next_s;
  logic [rpmc_pkg::NUM_SRC-1:0] src_rise;
  logic                         src_edge;
  logic                         run;
  logic                         tick;
  logic                         wrap;
  logic                         do_write;
  logic                         wr_sc;
  logic                         wr_lim;
  logic                         wr_cnt;
  logic                         flag_clr;
  logic                         cfg_clear;
  logic [rpmc_pkg::PRESC_W-1:0] div;

  // Map a byte address to a register
  function automatic rpmc_pkg::rpmc_sel_type rpmc_decode(
      input logic [rpmc_pkg::AXI_ADDR_W-1:0] a);
    rpmc_pkg::rpmc_sel_type r;
    r = rpmc_pkg::RPMC_SEL_NONE;
    case (a)
      rpmc_pkg::OFF_STATUS_CTL: r = rpmc_pkg::RPMC_SEL_SC;
      rpmc_pkg::OFF_CUR_COUNT:  r = rpmc_pkg::RPMC_SEL_CNT;
      rpmc_pkg::OFF_MATCH_LIM:  r = rpmc_pkg::RPMC_SEL_LIM;
      default:                  r = rpmc_pkg::RPMC_SEL_NONE;
    endcase
    return r;
  endfunction

  // ************************************************************
  // Source clock synchronisers
  // ************************************************************
  rpmc_src_sync #(
    .N (rpmc_pkg::NUM_SRC)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .src_clk  ({internal_ref_clock, external_ref_clock, low_power_osc_clock}),
    .src_rise (src_rise)
  );

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    next_s    = s;
    src_edge  = 1'b0;
    run       = 1'b0;
    tick      = 1'b0;
    wrap      = 1'b0;
    do_write  = 1'b0;
    wr_sc     = 1'b0;
    wr_lim    = 1'b0;
    wr_cnt    = 1'b0;
    flag_clr  = 1'b0;
    cfg_clear = 1'b0;
    div       = rpmc_pkg::rpmc_divisor(s.prescale_select, s.source_clock_select[0]);

    case (s.source_clock_select)
      2'h0:    src_edge = src_rise[0];
      2'h1:    src_edge = src_rise[1];
      default: src_edge = src_rise[2];
    endcase

    // prescale zero keeps the prescaler off
    // in deep stop only the low-power source keeps running
    // wait mode does not gate the counter
    run = (s.prescale_select != rpmc_pkg::PS_OFF) && !debug_active &&
          !(stop_deep && (s.source_clock_select != rpmc_pkg::SRC_LOW_POWER));

    // prescaler divides source edges by the selected ratio
    if (run && src_edge) begin
      if (s.presc >= div - 18'h00001) begin
        next_s.presc = '0;
        tick         = 1'b1;
      end else begin
        next_s.presc = s.presc + 18'h00001;
      end
    end

    // up-counter compared with the match limit
    // wrap to zero on the tick after a match
    if (tick) begin
      if (s.current_count == s.match_limit) begin
        next_s.current_count = rpmc_pkg::RST_COUNT;
        wrap                 = 1'b1;
      end else begin
        next_s.current_count = s.current_count + 8'h01;
      end
    end

    // Write channel capture, either order
    if (axi_req.awvalid && s.rsp.awready) begin
      next_s.have_aw = 1'b1;
      next_s.waddr   = axi_req.awaddr;
    end
    if (axi_req.wvalid && s.rsp.wready) begin
      next_s.have_w = 1'b1;
      next_s.wdata  = axi_req.wdata;
      next_s.wstrb  = axi_req.wstrb;
    end
    if (s.rsp.bvalid && axi_req.bready) begin
      next_s.rsp.bvalid = 1'b0;
    end

    // Register write once address and data are both held
    do_write = s.have_aw && s.have_w && !s.rsp.bvalid;
    if (do_write) begin
      next_s.have_aw    = 1'b0;
      next_s.have_w     = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp  = rpmc_pkg::RESP_OKAY;
      case (rpmc_decode(s.waddr))
        rpmc_pkg::RPMC_SEL_SC:  wr_sc  = s.wstrb[0];
        rpmc_pkg::RPMC_SEL_LIM: wr_lim = s.wstrb[0];
        rpmc_pkg::RPMC_SEL_CNT: wr_cnt = s.wstrb[0];
        default:                next_s.rsp.bresp = rpmc_pkg::RESP_SLVERR;
      endcase
    end

    if (wr_sc) begin
      // written one clears the flag, zero does nothing
      flag_clr = s.wdata[rpmc_pkg::BIT_FLAG];
      next_s.match_irq_enable = s.wdata[rpmc_pkg::BIT_IRQ_EN];
      next_s.source_clock_select = s.wdata[rpmc_pkg::BIT_SRC_HI:rpmc_pkg::BIT_SRC_LO];
      next_s.prescale_select = s.wdata[rpmc_pkg::BIT_PS_HI:rpmc_pkg::BIT_PS_LO];
      cfg_clear = (s.wdata[rpmc_pkg::BIT_SRC_HI:rpmc_pkg::BIT_SRC_LO] != s.source_clock_select) ||
                  (s.wdata[rpmc_pkg::BIT_PS_HI:rpmc_pkg::BIT_PS_LO] != s.prescale_select);
    end
    if (wr_lim) begin
      next_s.match_limit = s.wdata[7:0];
      cfg_clear          = 1'b1;
    end
    if (cfg_clear) begin
      next_s.presc         = '0;
      next_s.current_count = rpmc_pkg::RST_COUNT;
    end

    // set wins over a same-cycle clear
    if (flag_clr) begin
      next_s.match_flag = 1'b0;
    end
    if (wrap) begin
      next_s.match_flag = 1'b1;
    end

    // the request is registered from the next flag and enable values
    next_s.irq = next_s.match_flag && next_s.match_irq_enable;

    // Read channel
    if (s.rsp.rvalid && axi_req.rready) begin
      next_s.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && s.rsp.arready) begin
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.rresp  = rpmc_pkg::RESP_OKAY;
      next_s.rsp.rdata  = 32'h00000000;
      case (rpmc_decode(axi_req.araddr))
        rpmc_pkg::RPMC_SEL_SC:  next_s.rsp.rdata[7:0] = {s.match_flag, s.source_clock_select,
                                                         s.match_irq_enable, s.prescale_select};
        rpmc_pkg::RPMC_SEL_CNT: next_s.rsp.rdata[7:0] = s.current_count;
        rpmc_pkg::RPMC_SEL_LIM: next_s.rsp.rdata[7:0] = s.match_limit;
        default:                next_s.rsp.rresp      = rpmc_pkg::RESP_SLVERR;
      endcase
    end

    // Ready flags stand from registers
    next_s.rsp.awready = !next_s.have_aw && !next_s.rsp.bvalid;
    next_s.rsp.wready  = !next_s.have_w && !next_s.rsp.bvalid;
    next_s.rsp.arready = !next_s.rsp.rvalid;
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s                     <= '0;
      s.current_count       <= rpmc_pkg::RST_COUNT;
      s.match_limit         <= rpmc_pkg::RST_LIMIT;
      s.prescale_select     <= rpmc_pkg::PS_OFF;
      s.source_clock_select <= rpmc_pkg::SRC_LOW_POWER;
      s.rsp.awready         <= 1'b1;
      s.rsp.wready          <= 1'b1;
      s.rsp.arready         <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs come straight from the state register
  assign axi_rsp   = s.rsp;
  assign match_irq = s.irq;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_match_tick;
    tick && (s.current_count == s.match_limit);
  endsequence

  sequence s_quiet_cfg;
    !cfg_clear;
  endsequence

  a_wrap_to_zero: assert property (s_match_tick |=> s.current_count == 8'h00)
    else $error("Count did not wrap to zero on a match tick");

  a_flag_on_wrap: assert property (s_match_tick |=> s.match_flag)
    else $error("Match flag not set after a match");

  a_set_wins: assert property (wrap && flag_clr |=> s.match_flag ##1 s.match_flag || !flag_clr)
    else $error("Flag lost when match and clear coincide");

  a_flag_clear: assert property (flag_clr && !wrap |=> !s.match_flag)
    else $error("Written one did not clear the flag");

  a_irq_follows: assert property (s.match_flag && s.match_irq_enable |-> match_irq)
    else $error("Interrupt request missing while flag and enable set");

  a_irq_masked: assert property (!s.match_irq_enable |-> !match_irq)
    else $error("Interrupt request with enable clear");

  a_limit_clear: assert property (wr_lim |=> s.current_count == 8'h00 && s.presc == '0)
    else $error("Limit write did not clear the counters");

  a_src_change: assert property (
      wr_sc && (s.wdata[6:5] != s.source_clock_select) |=> s.current_count == 8'h00)
    else $error("Source change did not clear the count");

  a_ps_change: assert property (
      wr_sc && (s.wdata[3:0] != s.prescale_select) |=> s.presc == '0)
    else $error("Prescale change did not clear the prescaler");

  a_debug_freeze: assert property (debug_active ##0 s_quiet_cfg |=> $stable(s.current_count))
    else $error("Count moved in debug mode");

  a_off_halts: assert property (
      (s.prescale_select == 4'h0) ##0 s_quiet_cfg |=> $stable(s.presc))
    else $error("Prescaler ran while off");

  a_stop_gate: assert property (
      (stop_deep && (s.source_clock_select != 2'h0)) ##0 s_quiet_cfg
      |=> $stable(s.current_count))
    else $error("Count moved on a reference source in deep stop");

  a_count_ro: assert property (wr_cnt && !tick |=> $stable(s.current_count))
    else $error("Write to count register changed the count");

  a_count_bound: assert property (
      s_quiet_cfg ##0 (s.current_count <= s.match_limit) |=> s.current_count <= s.match_limit)
    else $error("Count passed the match limit");

  // Count moves by one on a tick below the limit, and not at all without a tick
  a_count_step: assert property (
      (tick && (s.current_count != s.match_limit)) ##0 s_quiet_cfg
      |=> s.current_count == $past(s.current_count) + 8'h01)
    else $error("Count did not step by one on a tick");

  a_count_hold: assert property (!tick ##0 s_quiet_cfg |=> $stable(s.current_count))
    else $error("Count moved without a prescaler tick");

  // Enabled request follows a match on the next cycle
  a_irq_on_wrap: assert property (
      s_match_tick ##0 (s.match_irq_enable && !wr_sc) |=> match_irq)
    else $error("Interrupt request missing after an enabled match");

  // Answers stand until taken, and registers are one byte wide
  a_bresp_hold: assert property (
      s.rsp.bvalid && !axi_req.bready |=> s.rsp.bvalid && $stable(s.rsp.bresp))
    else $error("Write response dropped before it was taken");

  a_rdata_hold: assert property (
      s.rsp.rvalid && !axi_req.rready |=> s.rsp.rvalid && $stable(s.rsp.rdata))
    else $error("Read data changed before it was taken");

  a_rdata_upper: assert property (s.rsp.rvalid |-> s.rsp.rdata[31:8] == 24'h000000)
    else $error("Read data above the low byte not zero");

endmodule

`default_nettype wire

//--- tb/rpmc_tb.sv
// Self-checking bench of the periodic match counter with a reference model
`timescale 1ns/10ps
`default_nettype none

module tb;
  // ************************************************************
  // Signals, counters and model state
  // ************************************************************
  logic                       clk_sys = 1'b0;
  logic                       rst     = 1'b1;
  rpmc_pkg::rpmc_axi_req_type req     = '0;
  rpmc_pkg::rpmc_axi_rsp_type rsp;
  logic [2:0]                 src     = 3'h0;
  logic                       stp     = 1'b0;
  logic                       dbg     = 1'b0;
  logic                       irq;
  logic [31:0]                rd;
  logic [1:0]                 rr;
  logic [31:0]                seed    = 32'h8625d851;
  int                         error_cnt;
  int                         comparisons;
  int                         cyc;
  int                         m_cnt, m_pre, m_lim, m_flag, m_en, m_src, m_ps;
  int div_lo[16] = '{0, 8, 32, 64, 128, 256, 512, 1024, 1, 2, 4, 10, 16, 100, 500, 1000};
  int div_hi[16] = '{0, 1024, 2048, 4096, 8192, 16384, 32768, 65536, 1000, 2000, 5000,
                     10000, 20000, 50000, 100000, 200000};

  // Clock of 4 ns period
  always #2 clk_sys = ~clk_sys;

  rpmc_top dut (
    .clk_sys             (clk_sys),
    .rst                 (rst),
    .axi_req             (req),
    .axi_rsp             (rsp),
    .low_power_osc_clock (src[0]),
    .external_ref_clock  (src[1]),
    .internal_ref_clock  (src[2]),
    .stop_deep           (stp),
    .debug_active        (dbg),
    .match_irq           (irq)
  );

  // ************************************************************
  // Reporting
  // ************************************************************
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Cuts a hang short
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      error_cnt = error_cnt + 1;
      test_done();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    y = y ^ (y << 5);
    return y;
  endfunction

  // ************************************************************
  // Bus master: each channel held until its own ready
  // ************************************************************
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= {24'h000000, d};
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while ((req.awvalid && !rsp.awready) || (req.wvalid && !rsp.wready));
    while (rsp.bvalid !== 1'b1) @(posedge clk_sys);
    rr = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] a);
    @(posedge clk_sys);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (!rsp.arready);
    req.arvalid <= 1'b0;
    while (rsp.rvalid !== 1'b1) @(posedge clk_sys);
    rd = rsp.rdata;
    rr = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  // ************************************************************
  // Model updates and comparisons
  // ************************************************************
  task automatic wr_sc(input logic [7:0] d);
    axi_wr(rpmc_pkg::OFF_STATUS_CTL, d);
    if (int'(d[6:5]) != m_src || int'(d[3:0]) != m_ps) begin
      m_pre = 0;
      m_cnt = 0;
    end
    if (d[7]) m_flag = 0;
    m_src = d[6:5];
    m_en  = d[4];
    m_ps  = d[3:0];
  endtask

  task automatic wr_lim(input logic [7:0] d);
    axi_wr(rpmc_pkg::OFF_MATCH_LIM, d);
    m_lim = d;
    m_pre = 0;
    m_cnt = 0;
  endtask

  task automatic chk_all();
    axi_rd(rpmc_pkg::OFF_STATUS_CTL);
    check("status_control", rd, {24'h0, m_flag[0], m_src[1:0], m_en[0], m_ps[3:0]});
    axi_rd(rpmc_pkg::OFF_CUR_COUNT);
    check("current_count", rd, 32'(m_cnt));
    axi_rd(rpmc_pkg::OFF_MATCH_LIM);
    check("match_limit", rd, 32'(m_lim));
    check("rresp", 32'(rr), 32'(rpmc_pkg::RESP_OKAY));
    check("match_irq", 32'(irq), 32'(m_flag & m_en));
  endtask

  // Drives n rising edges on one source and advances the model
  task automatic pulse(input int s, input int n);
    int sel;
    sel = m_src[1] ? 2 : m_src[0];
    repeat (n) begin
      @(posedge clk_sys);
      src[s] <= 1'b1;
      repeat (3) @(posedge clk_sys);
      src[s] <= 1'b0;
      repeat (2) @(posedge clk_sys);
      if (s == sel && m_ps != 0 && !dbg && !(stp && s != 0)) begin
        m_pre = m_pre + 1;
        if (m_pre >= (m_src[0] ? div_hi[m_ps] : div_lo[m_ps])) begin
          m_pre = 0;
          if (m_cnt == m_lim) begin
            m_cnt  = 0;
            m_flag = 1;
          end else begin
            m_cnt = m_cnt + 1;
          end
        end
      end
    end
    repeat (8) @(posedge clk_sys);
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    chk_all();
    // Unmapped place answers with an error
    axi_rd(12'h00c);
    check("unmapped rresp", 32'(rr), 32'(rpmc_pkg::RESP_SLVERR));
    check("unmapped rdata", rd, 32'h0);
    axi_wr(12'h00c, 8'hff);
    check("unmapped bresp", 32'(rr), 32'(rpmc_pkg::RESP_SLVERR));
    // Count ignores writes, prescale off halts
    axi_wr(rpmc_pkg::OFF_CUR_COUNT, 8'h5a);
    pulse(0, 4);
    chk_all();
    // Match, wrap, enable and flag clear
    wr_sc(8'h08);
    wr_lim(8'h03);
    pulse(0, 4);
    chk_all();
    pulse(0, 1);
    wr_sc(8'h18);
    chk_all();
    wr_sc(8'h98);
    chk_all();
    // Source routing for every select code
    pulse(1, 3);
    pulse(2, 3);
    chk_all();
    for (int k = 1; k < 4; k++) begin
      wr_sc({1'b0, 2'(k), 1'b1, 4'h8});
      pulse((k == 1) ? 1 : 2, 3);
      pulse(0, 2);
      chk_all();
    end
    // Deep stop gates the reference sources only
    wr_sc(8'h58);
    stp <= 1'b1;
    pulse(2, 3);
    chk_all();
    wr_sc(8'h18);
    pulse(0, 3);
    chk_all();
    stp <= 1'b0;
    // Debug freezes and counting resumes
    dbg <= 1'b1;
    pulse(0, 3);
    dbg <= 1'b0;
    chk_all();
    pulse(0, 2);
    chk_all();
    // Counter stopped by software stays put while its source keeps pulsing
    wr_sc(8'h10);
    pulse(0, 3);
    chk_all();
    // Every prescale ratio on the low-power source, then 1024 on the internal reference
    wr_lim(8'hff);
    for (int p = 1; p < 16; p++) begin
      wr_sc({4'h0, 4'(p)});
      pulse(0, div_lo[p] + div_lo[p] / 2 + 1);
      chk_all();
    end
    wr_sc(8'h61);
    pulse(2, 1537);
    chk_all();
    // External reference at its smallest decimal ratio
    wr_sc(8'h28);
    pulse(1, 1001);
    pulse(0, 2);
    chk_all();
    // Random limits, counts and flag clears
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      wr_lim(8'(seed[2:0]));
      wr_sc({seed[8], 2'h0, seed[9], 4'h8});
      pulse(0, int'(seed[14:10]));
      chk_all();
    end
    test_done();
  end
endmodule

`default_nettype wire
